// ==== hw/frm_pkg.sv ====
// Constants, carrier structs and enumerations for the fault response manager
package frm_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ            = 250000;
    localparam int RETRY_FAST_MS      = 100;
    localparam int RETRY_SLOW_MS      = 1000;
    localparam int RETRY_FAST_CYCLES  = RETRY_FAST_MS * CLK_KHZ;
    localparam int RETRY_SLOW_CYCLES  = RETRY_SLOW_MS * CLK_KHZ;
    localparam int REPORT_LAG_MAX_MS  = 200;
    localparam int CLEAR_LAG_MAX_MS   = 200;
    localparam int CNT_W              = 32;

    // ------------------------------------------------------------------
    // Bus current limit
    // ------------------------------------------------------------------
    localparam int REF_W              = 16;
    localparam int HYST_PCT           = 5;
    localparam int PCT_FULL           = 100;

    // ------------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] OCP_LATCHED   = 2'h0;
    localparam logic [1:0] OCP_RETRY     = 2'h1;
    localparam logic       SETTING_ON    = 1'h1;
    localparam logic       PULSE_RST     = 1'h0;
    localparam logic       LIMIT_RST     = 1'h0;
    localparam logic       STAGE_RST     = 1'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic motorSupplyLow;
        logic analogSupplyLow;
        logic chargePumpLowVoltage;
        logic overvoltage;
        logic phaseOvercurrent;
        logic regulatorLowVoltage;
        logic regulatorOvercurrent;
        logic slowRetryFault;
        logic reportOnlyFault;
    } frm_pins_t;

    typedef struct packed {
        logic chargePumpLowVoltage;
        logic overvoltage;
        logic phaseOvercurrent;
    } frm_gate_flags_t;

    typedef enum logic [2:0] {
        FRM_NONE       = 3'h0,
        FRM_REPORT     = 3'h1,
        FRM_RETRY_FAST = 3'h3,
        FRM_RETRY_SLOW = 3'h2,
        FRM_LATCHED    = 3'h6
    } frm_class_t;

endpackage : frm_pkg

// ==== hw/fault_response_manager.sv ====
// Fault supervision, reporting, recovery and bus current limiting
`timescale 1ns/1ns
// Overview of operation
// - In fault state the speed pulse output holds the fault level setting.
// - In idle state the speed pulse output holds the idle level setting.
// - Current limiting works only when enabled; threshold from the limit value input.
// - While limiting, limited speed and current references are lowered.
// - A status output shows when current limiting restricts the reference.
// - Limiting engages at the limit and releases five percent below it.
// - Every actionable fault pulls the fault output low while the core is on.
// - With alarm enabled and the core on, actionable faults also drive the alarm pin high.
// - Report-only faults use fault pin if alarm disabled, else alarm only.
// - Priority is latched, slow retry, fast retry, then report-only.
// - Two retry faults together re-enable only after the longer interval.
// - Latched fault keeps power stage off until the clear bit is written.
// - Retry faults re-enable the stage after the interval following removal.
// - Fault reporting lags stage shutdown by at most 200 ms.
// - A clear command finishes clearing a latched fault within 200 ms.
// - Motor or analog supply low: stage off, core off, no report, auto recover.
// - Charge pump low: stage off, core on, reported, auto recover.
// - Overvoltage ignored when disabled; else stage off, reported, auto recover.
// - Phase overcurrent: stage off, reported; latched or timed retry per select.
module fault_response_manager #(
    parameter int RETRY_FAST_CYCLES = frm_pkg::RETRY_FAST_CYCLES,
    parameter int RETRY_SLOW_CYCLES = frm_pkg::RETRY_SLOW_CYCLES,
    parameter int REF_W             = frm_pkg::REF_W
) (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    // Fault detector pins, asynchronous
    input  wire frm_pkg::frm_pins_t      faultPins,
    // Configuration and commands
    input  wire logic                    pulseLevelInFault,
    input  wire logic                    pulseLevelInIdle,
    input  wire logic                    overvoltageProtectEnable,
    input  wire logic [1:0]              overcurrentResponseSelect,
    input  wire logic                    alarmPinEnable,
    input  wire logic                    clearFaultBit,
    // Speed pulse path
    input  wire logic                    speedPulseRaw,
    input  wire logic                    speedCommandZero,
    output logic                         speedPulseOutput,
    // Bus current limit
    input  wire logic                    busCurrentLimitEnable,
    input  wire logic [REF_W-1:0]        busCurrentLimit,
    input  wire logic [REF_W-1:0]        busCurrent,
    input  wire logic [REF_W-1:0]        speedReference,
    input  wire logic [REF_W-1:0]        currentReference,
    output logic [REF_W-1:0]             limitedSpeedReference,
    output logic [REF_W-1:0]             limitedCurrentReference,
    output logic                         busCurrentLimitStatus,
    // Fault reporting and power stage
    output logic                         faultOutputLow_n,
    output logic                         alarmOutput,
    output logic                         powerStageEnable,
    output logic                         digitalCoreEnable,
    output frm_pkg::frm_gate_flags_t     gateStageFaultFlags,
    output frm_pkg::frm_class_t          faultClass
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Retry timer: reloads while the condition is present, counts down after
    function automatic logic [frm_pkg::CNT_W:0] retryStep(
        input logic                      cond,
        input logic                      pending,
        input logic [frm_pkg::CNT_W-1:0] cnt,
        input logic [frm_pkg::CNT_W-1:0] reload
    );
        logic [frm_pkg::CNT_W:0] r;
        r = {pending, cnt};
        if (cond) begin
            r = {1'h1, reload};
        end else if (pending && cnt != '0) begin
            r = {1'h1, cnt - frm_pkg::CNT_W'(1)};
        end else begin
            r = {1'h0, {frm_pkg::CNT_W{1'h0}}};
        end
        return r;
    endfunction : retryStep

    // Reference tracker: steps down while limiting, follows the command otherwise
    function automatic logic [REF_W-1:0] refStep(
        input logic             limiting,
        input logic [REF_W-1:0] cur,
        input logic [REF_W-1:0] cmd
    );
        logic [REF_W-1:0] r;
        r = cur;
        if (cur > cmd) begin
            r = cmd;
        end else if (limiting) begin
            if (cur != '0) begin
                r = cur - REF_W'(1);
            end
        end else if (cur < cmd) begin
            r = cur + REF_W'(1);
        end
        return r;
    endfunction : refStep

    // Release threshold of the limit comparison
    function automatic logic [REF_W-1:0] releaseLevel(
        input logic [REF_W-1:0] limit
    );
        logic [REF_W+7:0] scaled;
        scaled = '0;
        scaled = (REF_W+8)'(limit) * (REF_W+8)'(frm_pkg::PCT_FULL - frm_pkg::HYST_PCT);
        scaled = scaled / (REF_W+8)'(frm_pkg::PCT_FULL);
        return scaled[REF_W-1:0];
    endfunction : releaseLevel

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    frm_pkg::frm_pins_t pinMeta_reg;
    frm_pkg::frm_pins_t pinSync_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_reg <= '0;
            pinSync_reg <= '0;
        end else begin
            pinMeta_reg <= faultPins;
            pinSync_reg <= pinMeta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Fault state
    // ------------------------------------------------------------------
    logic                      latched_reg;
    logic                      latched_next;
    logic                      fastPending_reg;
    logic                      fastPending_next;
    logic [frm_pkg::CNT_W-1:0] fastCnt_reg;
    logic [frm_pkg::CNT_W-1:0] fastCnt_next;
    logic                      slowPending_reg;
    logic                      slowPending_next;
    logic [frm_pkg::CNT_W-1:0] slowCnt_reg;
    logic [frm_pkg::CNT_W-1:0] slowCnt_next;
    logic                      ocpRetryMode;
    logic                      ovpActive;
    logic                      coreOff;
    logic                      autoStageOff;
    logic                      actionable;
    logic                      reportOnly;

    always_comb begin
        ocpRetryMode = (overcurrentResponseSelect == frm_pkg::OCP_RETRY);
        ovpActive    = pinSync_reg.overvoltage && (overvoltageProtectEnable == frm_pkg::SETTING_ON);
        // Set wins over clear; clear takes hold only once the condition is gone
        latched_next = (pinSync_reg.phaseOvercurrent && !ocpRetryMode)
                     || (latched_reg && !clearFaultBit);
        {fastPending_next, fastCnt_next} = retryStep(pinSync_reg.phaseOvercurrent && ocpRetryMode,
                                                     fastPending_reg, fastCnt_reg,
                                                     frm_pkg::CNT_W'(RETRY_FAST_CYCLES));
        {slowPending_next, slowCnt_next} = retryStep(pinSync_reg.slowRetryFault,
                                                     slowPending_reg, slowCnt_reg,
                                                     frm_pkg::CNT_W'(RETRY_SLOW_CYCLES));
        coreOff      = pinSync_reg.motorSupplyLow || pinSync_reg.analogSupplyLow
                     || pinSync_reg.regulatorOvercurrent;
        autoStageOff = coreOff || pinSync_reg.chargePumpLowVoltage || ovpActive
                     || pinSync_reg.regulatorLowVoltage;
        actionable   = latched_reg || fastPending_reg || slowPending_reg
                     || pinSync_reg.chargePumpLowVoltage || ovpActive;
        reportOnly   = pinSync_reg.reportOnlyFault;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latched_reg     <= 1'h0;
            fastPending_reg <= 1'h0;
            fastCnt_reg     <= '0;
            slowPending_reg <= 1'h0;
            slowCnt_reg     <= '0;
        end else begin
            latched_reg     <= latched_next;
            fastPending_reg <= fastPending_next;
            fastCnt_reg     <= fastCnt_next;
            slowPending_reg <= slowPending_next;
            slowCnt_reg     <= slowCnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Reporting and power stage
    // ------------------------------------------------------------------
    frm_pkg::frm_class_t      class_reg;
    frm_pkg::frm_class_t      class_next;
    logic                     faultLow_reg;
    logic                     faultLow_next;
    logic                     alarm_reg;
    logic                     alarm_next;
    logic                     stage_reg;
    logic                     stage_next;
    logic                     core_reg;
    logic                     core_next;
    logic                     pulse_reg;
    logic                     pulse_next;
    frm_pkg::frm_gate_flags_t flags_reg;
    frm_pkg::frm_gate_flags_t flags_next;

    always_comb begin
        // Highest ranking fault present sets the response
        if (latched_reg) begin
            class_next = frm_pkg::FRM_LATCHED;
        end else if (slowPending_reg) begin
            class_next = frm_pkg::FRM_RETRY_SLOW;
        end else if (fastPending_reg) begin
            class_next = frm_pkg::FRM_RETRY_FAST;
        end else if (reportOnly) begin
            class_next = frm_pkg::FRM_REPORT;
        end else begin
            class_next = frm_pkg::FRM_NONE;
        end
        // Undervoltage of motor or analog supply is not reported
        faultLow_next = !coreOff && (actionable
                      || (reportOnly && alarmPinEnable != frm_pkg::SETTING_ON));
        alarm_next    = !coreOff && (alarmPinEnable == frm_pkg::SETTING_ON)
                      && (actionable || reportOnly);
        // Both retry timers must lapse, so the longer one decides
        stage_next    = !latched_reg && !fastPending_reg && !slowPending_reg && !autoStageOff
                      && !latched_next && !fastPending_next && !slowPending_next;
        core_next     = !coreOff;
        flags_next.chargePumpLowVoltage = pinSync_reg.chargePumpLowVoltage;
        flags_next.overvoltage          = ovpActive;
        flags_next.phaseOvercurrent     = latched_reg || fastPending_reg
                                        || pinSync_reg.phaseOvercurrent;
        if (actionable) begin
            pulse_next = pulseLevelInFault;
        end else if (speedCommandZero) begin
            pulse_next = pulseLevelInIdle;
        end else begin
            pulse_next = speedPulseRaw;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            class_reg    <= frm_pkg::FRM_NONE;
            faultLow_reg <= 1'h0;
            alarm_reg    <= 1'h0;
            stage_reg    <= frm_pkg::STAGE_RST;
            core_reg     <= 1'h0;
            pulse_reg    <= frm_pkg::PULSE_RST;
            flags_reg    <= '0;
        end else begin
            class_reg    <= class_next;
            faultLow_reg <= faultLow_next;
            alarm_reg    <= alarm_next;
            stage_reg    <= stage_next;
            core_reg     <= core_next;
            pulse_reg    <= pulse_next;
            flags_reg    <= flags_next;
        end
    end

    // ------------------------------------------------------------------
    // Bus current limit
    // ------------------------------------------------------------------
    logic             limit_reg;
    logic             limit_next;
    logic [REF_W-1:0] speedLim_reg;
    logic [REF_W-1:0] speedLim_next;
    logic [REF_W-1:0] currentLim_reg;
    logic [REF_W-1:0] currentLim_next;

    always_comb begin
        if (busCurrentLimitEnable != frm_pkg::SETTING_ON) begin
            limit_next = 1'h0;
        end else if (busCurrent >= busCurrentLimit) begin
            limit_next = 1'h1;
        end else if (busCurrent < releaseLevel(busCurrentLimit)) begin
            limit_next = 1'h0;
        end else begin
            limit_next = limit_reg;
        end
        speedLim_next   = refStep(limit_reg, speedLim_reg, speedReference);
        currentLim_next = refStep(limit_reg, currentLim_reg, currentReference);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            limit_reg      <= frm_pkg::LIMIT_RST;
            speedLim_reg   <= '0;
            currentLim_reg <= '0;
        end else begin
            limit_reg      <= limit_next;
            speedLim_reg   <= speedLim_next;
            currentLim_reg <= currentLim_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign speedPulseOutput        = pulse_reg;
    assign faultOutputLow_n        = !faultLow_reg;
    assign alarmOutput             = alarm_reg;
    assign powerStageEnable        = stage_reg;
    assign digitalCoreEnable       = core_reg;
    assign gateStageFaultFlags     = flags_reg;
    assign faultClass              = class_reg;
    assign busCurrentLimitStatus   = limit_reg;
    assign limitedSpeedReference   = speedLim_reg;
    assign limitedCurrentReference = currentLim_reg;

endmodule : fault_response_manager

// ==== verification/frm_props.sv ====
// Port checks for the fault response manager
`timescale 1ns/1ns
module frm_props #(
    parameter int REF_W = 16
) (
    // Clock, reset, settings and inputs
    input wire logic                     mclk,
    input wire logic                     rst_n,
    input wire logic                     pulseLevelInFault,
    input wire logic                     alarmPinEnable,
    input wire logic                     clearFaultBit,
    input wire logic                     busCurrentLimitEnable,
    input wire logic [REF_W-1:0]         busCurrentLimit,
    input wire logic [REF_W-1:0]         busCurrent,
    input wire frm_pkg::frm_pins_t       faultPins,
    // Observed outputs
    input wire logic                     speedPulseOutput,
    input wire logic [REF_W-1:0]         limitedSpeedReference,
    input wire logic                     busCurrentLimitStatus,
    input wire logic                     faultOutputLow_n,
    input wire logic                     alarmOutput,
    input wire logic                     powerStageEnable,
    input wire frm_pkg::frm_gate_flags_t gateStageFaultFlags,
    input wire frm_pkg::frm_class_t      faultClass
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic latched, actionable;
    assign latched    = faultClass == frm_pkg::FRM_LATCHED;
    assign actionable = latched || faultClass inside {frm_pkg::FRM_RETRY_FAST, frm_pkg::FRM_RETRY_SLOW};
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_fault_level: assert property (
        latched && $past(latched) |-> speedPulseOutput == $past(pulseLevelInFault))
        else $error("pulse output not at fault level");
    a_limit_engage: assert property (
        busCurrentLimitEnable && busCurrent >= busCurrentLimit |=> busCurrentLimitStatus)
        else $error("limit did not engage");
    a_limit_release: assert property (
        busCurrentLimitEnable && 32'(busCurrent) < 32'(busCurrentLimit) * 95 / 100 |=> !busCurrentLimitStatus)
        else $error("limit did not release");
    a_ref_lowered: assert property (
        busCurrentLimitStatus ##1 busCurrentLimitStatus |-> limitedSpeedReference <= $past(limitedSpeedReference))
        else $error("reference rose while limiting");
    a_fault_pin: assert property (
        actionable |-> !faultOutputLow_n)
        else $error("fault pin high on actionable fault");
    a_alarm_pin: assert property (
        actionable && $past(alarmPinEnable) |-> alarmOutput)
        else $error("alarm low on actionable fault");
    a_report_only: assert property (
        faultClass == frm_pkg::FRM_REPORT && gateStageFaultFlags == '0
        |-> faultOutputLow_n == $past(alarmPinEnable) && alarmOutput == $past(alarmPinEnable))
        else $error("report-only pins wrong");
    a_pins_release: assert property (
        faultClass == frm_pkg::FRM_NONE && gateStageFaultFlags == '0 |-> faultOutputLow_n && !alarmOutput)
        else $error("pins not released");
    a_latch_holds: assert property (
        latched && $past(latched) && !$past(clearFaultBit) |-> !powerStageEnable)
        else $error("stage on while latched");
    a_clear_recovers: assert property (
        clearFaultBit && latched && $past(faultPins) == '0 && $past(faultPins, 2) == '0 |-> ##[1:4] powerStageEnable)
        else $error("clear did not restore stage");
endmodule : frm_props

bind fault_response_manager frm_props #(.REF_W(REF_W)) u_props (.mclk, .rst_n, .pulseLevelInFault, .alarmPinEnable,
    .clearFaultBit, .busCurrentLimitEnable, .busCurrentLimit, .busCurrent, .faultPins, .speedPulseOutput,
    .limitedSpeedReference, .busCurrentLimitStatus, .faultOutputLow_n, .alarmOutput, .powerStageEnable,
    .gateStageFaultFlags, .faultClass);

// ==== verification/frm_host_model.sv ====
// Host controller that watches the fault pin and writes the clear command
`timescale 1ns/1ns
module frm_host_model (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Fault pin and clear command
    input  wire logic faultOutputLow_n,
    input  wire logic clearRequest,
    output logic      clearFaultBit
);
    // One-cycle clear write, only while a fault is shown
    always @(negedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clearFaultBit <= 1'h0;
        end else begin
            clearFaultBit <= clearRequest && !faultOutputLow_n;
        end
    end
endmodule : frm_host_model

// ==== verification/fault_response_manager_tb_top.sv ====
// Self-checking bench for the fault response manager
`timescale 1ns/1ns
module fault_response_manager_tb_top;
    localparam int FAST = 20, SLOW = 50;
    localparam int K_STAGE = 0, K_FPIN = 1, K_ALARM = 2, K_CLASS = 3, K_FLAGS = 4;
    localparam int K_PULSE = 5, K_STATUS = 6, K_CORE = 7, K_LOWER = 8;
    typedef struct {int code; logic [15:0] val;} frm_note_t;
    logic                     mclk, rst_n, clearFaultBit, clearRequest;
    frm_pkg::frm_pins_t       faultPins;
    logic                     pulseLevelInFault, pulseLevelInIdle, overvoltageProtectEnable, alarmPinEnable;
    logic [1:0]               overcurrentResponseSelect;
    logic                     speedPulseRaw, speedCommandZero, speedPulseOutput, busCurrentLimitEnable;
    logic [15:0]              busCurrentLimit, busCurrent, speedReference, currentReference, lim;
    logic [15:0]              limitedSpeedReference, limitedCurrentReference, act;
    logic                     busCurrentLimitStatus, faultOutputLow_n, alarmOutput, powerStageEnable, digitalCoreEnable;
    frm_pkg::frm_gate_flags_t gateStageFaultFlags;
    frm_pkg::frm_class_t      faultClass;
    frm_note_t                notes[$], nt;
    int                       fails = 0;
    int                       n_compared = 0;
    event                     chk;

    fault_response_manager #(.RETRY_FAST_CYCLES(FAST), .RETRY_SLOW_CYCLES(SLOW)) dut_u (.mclk, .rst_n, .faultPins,
        .pulseLevelInFault, .pulseLevelInIdle, .overvoltageProtectEnable, .overcurrentResponseSelect, .alarmPinEnable,
        .clearFaultBit, .speedPulseRaw, .speedCommandZero, .speedPulseOutput, .busCurrentLimitEnable, .busCurrentLimit,
        .busCurrent, .speedReference, .currentReference, .limitedSpeedReference, .limitedCurrentReference,
        .busCurrentLimitStatus, .faultOutputLow_n, .alarmOutput, .powerStageEnable, .digitalCoreEnable,
        .gateStageFaultFlags, .faultClass);
    frm_host_model u_host (.mclk, .rst_n, .faultOutputLow_n, .clearRequest, .clearFaultBit);

    initial mclk = 1'h0;
    always #2 mclk = ~mclk;
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic compare(input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : compare
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic note(input int code, input logic [15:0] val);
        notes.push_back('{code, val});
        -> chk;
    endtask : note
    task automatic pins(input logic [8:0] p);
        faultPins = p;
        speedPulseRaw = 1'($urandom);
        cyc(6);
    endtask : pins
    task automatic clearFault;
        int i;
        clearRequest <= 1'h1;
        cyc(1);
        clearRequest <= 1'h0;
        for (i = 0; i < 100 && faultOutputLow_n !== 1'h1; i++) cyc(1);
        note(K_FPIN, 16'h1);
        cyc(2);
        note(K_STAGE, 16'h1);
        note(K_ALARM, 16'h0);
    endtask : clearFault
    // ------------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------------
    always begin
        @(chk);
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            case (nt.code)
                K_STAGE:  act = {15'h0, powerStageEnable};
                K_FPIN:   act = {15'h0, faultOutputLow_n};
                K_ALARM:  act = {15'h0, alarmOutput};
                K_CLASS:  act = {13'h0, faultClass};
                K_FLAGS:  act = {13'h0, gateStageFaultFlags};
                K_PULSE:  act = {15'h0, speedPulseOutput};
                K_STATUS: act = {15'h0, busCurrentLimitStatus};
                K_CORE:   act = {15'h0, digitalCoreEnable};
                default:  act = {14'h0, limitedCurrentReference < currentReference, limitedSpeedReference < speedReference};
            endcase
            compare(nt.val, act);
        end
    end
    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h8fba));
        {rst_n, clearRequest, pulseLevelInFault, pulseLevelInIdle, overvoltageProtectEnable, alarmPinEnable} = '0;
        {speedPulseRaw, speedCommandZero, busCurrentLimitEnable, overcurrentResponseSelect} = '0;
        {busCurrentLimit, busCurrent, speedReference, currentReference} = '0;
        faultPins = '0;
        cyc(16);
        rst_n = 1'h1;
        pins(9'h000);
        speedCommandZero = 1'h1;
        for (int i = 0; i < 2; i++) begin
            pulseLevelInIdle = i[0];
            pins(9'h000);
            note(K_PULSE, 16'(i[0]));
        end
        speedCommandZero = 1'h0;
        alarmPinEnable = 1'h1;
        for (int m = 0; m < 2; m++) begin
            overcurrentResponseSelect = 2'(m);
            pulseLevelInFault = 1'($urandom);
            pins(9'h010);
            note(K_STAGE, 16'h0);
            note(K_FPIN, 16'h0);
            note(K_ALARM, 16'h1);
            note(K_FLAGS, 16'h1);
            note(K_CLASS, 16'(m ? frm_pkg::FRM_RETRY_FAST : frm_pkg::FRM_LATCHED));
            note(K_PULSE, 16'(pulseLevelInFault));
            pins(9'h000);
            cyc(FAST - 8);
            note(K_STAGE, 16'h0);
            cyc(SLOW);
            note(K_STAGE, 16'(m));
            if (m == 0) clearFault();
        end
        pins(9'h012);
        note(K_CLASS, 16'(frm_pkg::FRM_RETRY_SLOW));
        pins(9'h000);
        cyc(FAST + 10);
        note(K_STAGE, 16'h0);
        cyc(SLOW);
        note(K_STAGE, 16'h1);
        overcurrentResponseSelect = 2'h0;
        pins(9'h012);
        note(K_CLASS, 16'(frm_pkg::FRM_LATCHED));
        pins(9'h000);
        cyc(SLOW + 10);
        note(K_STAGE, 16'h0);
        clearFault();
        for (int a = 0; a < 2; a++) begin
            alarmPinEnable = a[0];
            pins(9'h001);
            note(K_FPIN, 16'(a[0]));
            note(K_ALARM, 16'(a[0]));
            pins(9'h000);
            note(K_FPIN, 16'h1);
        end
        pins(9'h040);
        note(K_STAGE, 16'h0);
        note(K_CORE, 16'h1);
        note(K_FPIN, 16'h0);
        note(K_FLAGS, 16'h4);
        pins(9'h000);
        note(K_STAGE, 16'h1);
        for (int e = 0; e < 2; e++) begin
            overvoltageProtectEnable = e[0];
            pins(9'h020);
            note(K_STAGE, 16'(!e[0]));
            note(K_FPIN, 16'(!e[0]));
            note(K_FLAGS, e ? 16'h2 : 16'h0);
            pins(9'h000);
            note(K_STAGE, 16'h1);
        end
        for (int u = 0; u < 2; u++) begin
            pins(u ? 9'h080 : 9'h100);
            note(K_STAGE, 16'h0);
            note(K_CORE, 16'h0);
            note(K_FPIN, 16'h1);
            pins(9'h000);
            note(K_CORE, 16'h1);
        end
        lim = 16'(20 * (50 + $urandom % 2500));
        {speedReference, currentReference, busCurrentLimit, busCurrent} = {16'h0100, 16'h0100, lim, lim};
        cyc(300);
        note(K_STATUS, 16'h0);
        note(K_LOWER, 16'h0);
        busCurrentLimitEnable = 1'h1;
        cyc(20);
        note(K_STATUS, 16'h1);
        note(K_LOWER, 16'h3);
        busCurrent = 16'(32'(lim) * 95 / 100);
        cyc(3);
        note(K_STATUS, 16'h1);
        busCurrent = busCurrent - 16'h1;
        cyc(3);
        note(K_STATUS, 16'h0);
        cyc(2);
        end_sim();
    end
endmodule : fault_response_manager_tb_top
